// File: pkg/arf_defs.vh
// arf_defs.vh: constants of the converter result-format and reference-select block
// assumes: included by bare name from the design files, byte addresses on a 32-bit bus
`ifndef ARF_DEFS_VH
`define ARF_DEFS_VH

// register byte offsets
`define ARF_OFS_INPUT_SELECT 8'h00
`define ARF_OFS_RESULT_LOW 8'h04
`define ARF_OFS_RESULT_HIGH 8'h08
`define ARF_OFS_STATUS 8'h0C
`define ARF_OFS_IRQ_CLEAR 8'h10
`define ARF_OFS_IRQ_ENABLE 8'h14
`define ARF_OFS_ACTIVE_SELECT 8'h18

// input-select register layout and reset value
`define ARF_SEL_RESET 8'h00
`define ARF_REF_HI 7
`define ARF_REF_LO 6
`define ARF_LADJ_BIT 5
`define ARF_CHAN_HI 4
`define ARF_CHAN_LO 0

// reference choice codes
`define ARF_REF_EXTERNAL 2'h0
`define ARF_REF_SUPPLY 2'h1
`define ARF_REF_RESERVED 2'h2
`define ARF_REF_INTERNAL 2'h3

// channel codes bounding the differential pairs
`define ARF_DIFF_FIRST 5'h08
`define ARF_DIFF_LAST 5'h1D

// result code limits
`define ARF_SE_MAX 10'h3FF
`define ARF_SE_MIN 10'h000
`define ARF_DIFF_MAX 10'h1FF
`define ARF_DIFF_MIN 10'h200
`define ARF_RESULT_RESET 10'h000

// status and interrupt bit positions
`define ARF_ST_DONE_BIT 0
`define ARF_ST_BUSY_BIT 1

// bus answers
`define ARF_RESP_OKAY 2'h0
`define ARF_RESP_SLVERR 2'h2

`endif

// File: src/arf_result_format.v
// arf_result_format.v: result coding, justification and reference/channel selection
// of a 10-bit successive-approximation converter, with an AXI4-Lite register slave.
// assumes: neighbouring control logic on aclk pulses conv_start and conv_finish and
// supplies the raw scaled code; the analog side obeys the selection outputs.
//
// Function
// - finished value is visible in result bytes only once done flag is high
// - single-ended result is unsigned 10-bit code, 0x000 ground to 0x3FF
// - differential result is 10-bit two's complement, 0x200 through 0x1FF
// - differential results clamp at 0x1FF and 0x200; minus one step reads 0x3FF
// - sign of a differential result sits in result bit 9
// - reference code 0 external pin, 1 analog supply, 3 internal, 2 reserved
// - reference written mid-conversion applies only after that conversion ends
// - justify bit one gives left-justified result, zero gives right-justified
// - justify bit change rearranges visible result bytes at once
// - input-select register is 8 bits, read/write, reset zero, fields 7:6, 5, 4:0
// - done flag sets when conversion completes and result bytes are updated
// - channel/gain field picks input; mid-conversion change applies afterwards
// - left: bits 9:2 in high byte, 1:0 on top of low; right: 9:8 low of high
`timescale 1ns/1ps
`include "arf_defs.vh"

module arf_result_format #(
    parameter ADDR_W = 8,
    parameter RAW_W = 12
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // converter core handshake
    input wire conv_start,
    input wire conv_finish,
    input wire signed [RAW_W-1:0] conv_raw,
    output wire conv_busy,
    // selection applied to the analog side
    output reg [1:0] active_reference,
    output wire ref_use_external_pin,
    output wire ref_use_analog_supply,
    output wire ref_use_internal,
    output reg [4:0] active_channel_gain,
    output wire active_differential,
    // formatted result bytes
    output wire [7:0] result_low_byte,
    output wire [7:0] result_high_byte,
    output wire irq
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // true for channel codes that name a differential pair
    function is_diff;
        input [4:0] chan;
        begin
            is_diff = (chan >= `ARF_DIFF_FIRST) && (chan <= `ARF_DIFF_LAST);
        end
    endfunction

    // clamp the raw scaled code into the 10-bit result space
    function [9:0] clamp_code;
        input signed [RAW_W-1:0] raw;
        input diff;
        begin
            if (diff) begin
                if (raw > $signed(12'sd511)) begin
                    clamp_code = `ARF_DIFF_MAX;
                end else if (raw < $signed(-12'sd512)) begin
                    clamp_code = `ARF_DIFF_MIN;
                end else begin
                    clamp_code = raw[9:0];
                end
            end else begin
                if (raw < $signed(12'sd0)) begin
                    clamp_code = `ARF_SE_MIN;
                end else if (raw > $signed(12'sd1023)) begin
                    clamp_code = `ARF_SE_MAX;
                end else begin
                    clamp_code = raw[9:0];
                end
            end
        end
    endfunction

    // place the 10-bit result into the high:low byte pair
    function [15:0] justify;
        input [9:0] res;
        input left;
        begin
            if (left) begin
                justify = {res, 6'h00};
            end else begin
                justify = {6'h00, res};
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    reg [7:0] input_select_r;
    reg [9:0] result_r;
    reg busy_r;
    reg done_flag_r;
    reg irq_enable_r;
    reg aw_held_r;
    reg w_held_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg [15:0] shown_r;
    reg [9:0] result_nxt;
    reg [7:0] input_select_nxt;

    wire [15:0] shown_bytes;
    wire start_take;
    wire finish_take;
    wire wr_go;
    wire rd_take;
    wire wr_low_lane;
    wire clear_done;

    // ------------------------------------------------------------------
    // conversion sequencing
    // ------------------------------------------------------------------

    // a start is taken only when idle, a finish only while busy
    assign start_take = conv_start && !busy_r;
    assign finish_take = conv_finish && busy_r;
    assign conv_busy = busy_r;

    // busy window of the running conversion
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
        end else if (start_take) begin
            busy_r <= 1'b1;
        end else if (finish_take) begin
            busy_r <= 1'b0;
        end
    end

    // selection follows the register while idle, frozen while busy
    always @(posedge aclk) begin
        if (!aresetn) begin
            active_reference <= `ARF_REF_EXTERNAL;
            active_channel_gain <= 5'h00;
        end else if (!busy_r || finish_take) begin
            active_reference <= input_select_r[`ARF_REF_HI:`ARF_REF_LO];
            active_channel_gain <= input_select_r[`ARF_CHAN_HI:`ARF_CHAN_LO];
        end
    end

    // reference switches; reserved code falls back to the external pin
    assign ref_use_internal = (active_reference == `ARF_REF_INTERNAL);
    assign ref_use_analog_supply = (active_reference == `ARF_REF_SUPPLY);
    assign ref_use_external_pin = !ref_use_internal && !ref_use_analog_supply;
    assign active_differential = is_diff(active_channel_gain);

    // next result, coded with the frozen channel selection at completion
    always @* begin
        result_nxt = result_r;
        if (finish_take) begin
            result_nxt = clamp_code(conv_raw, active_differential);
        end
    end

    // result register, changes only at a taken finish
    always @(posedge aclk) begin
        if (!aresetn) begin
            result_r <= `ARF_RESULT_RESET;
        end else begin
            result_r <= result_nxt;
        end
    end

    // bytes built from next values so a justify write shows without delay
    always @(posedge aclk) begin
        if (!aresetn) begin
            shown_r <= {6'h00, `ARF_RESULT_RESET};
        end else begin
            shown_r <= justify(result_nxt, input_select_nxt[`ARF_LADJ_BIT]);
        end
    end
    assign shown_bytes = shown_r;
    assign result_high_byte = shown_bytes[15:8];
    assign result_low_byte = shown_bytes[7:0];

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_low_lane = w_strb_r[0];
    assign clear_done = wr_go && (aw_addr_r == `ARF_OFS_IRQ_CLEAR) && wr_low_lane
        && w_data_r[`ARF_ST_DONE_BIT];

    // hold write address and data until both have arrived
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= {ADDR_W{1'b0}};
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // next input-select value, only the low byte lane carries data
    always @* begin
        input_select_nxt = input_select_r;
        if (wr_go && wr_low_lane && (aw_addr_r == `ARF_OFS_INPUT_SELECT)) begin
            input_select_nxt = w_data_r[7:0];
        end
    end

    // register writes
    always @(posedge aclk) begin
        if (!aresetn) begin
            input_select_r <= `ARF_SEL_RESET;
            irq_enable_r <= 1'b0;
        end else begin
            input_select_r <= input_select_nxt;
            if (wr_go && wr_low_lane && (aw_addr_r == `ARF_OFS_IRQ_ENABLE)) begin
                irq_enable_r <= w_data_r[`ARF_ST_DONE_BIT];
            end
        end
    end

    // write response, error for unmapped or read-only offsets
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARF_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_r == `ARF_OFS_INPUT_SELECT) begin
                s_axi_bresp <= `ARF_RESP_OKAY;
            end else if (aw_addr_r == `ARF_OFS_IRQ_CLEAR) begin
                s_axi_bresp <= `ARF_RESP_OKAY;
            end else if (aw_addr_r == `ARF_OFS_IRQ_ENABLE) begin
                s_axi_bresp <= `ARF_RESP_OKAY;
            end else begin
                s_axi_bresp <= `ARF_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // done flag and interrupt
    // ------------------------------------------------------------------

    // sticky done flag; a completion beats a same-cycle clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            done_flag_r <= 1'b0;
        end else if (finish_take) begin
            done_flag_r <= 1'b1;
        end else if (clear_done) begin
            done_flag_r <= 1'b0;
        end
    end

    // level interrupt while an enabled flag stands
    assign irq = done_flag_r && irq_enable_r;

    // ------------------------------------------------------------------
    // read channel: one read at a time, answer one cycle after address
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // read data mux and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARF_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ARF_RESP_OKAY;
            if (s_axi_araddr == `ARF_OFS_INPUT_SELECT) begin
                s_axi_rdata <= {24'h000000, input_select_r};
            end else if (s_axi_araddr == `ARF_OFS_RESULT_LOW) begin
                s_axi_rdata <= {24'h000000, shown_bytes[7:0]};
            end else if (s_axi_araddr == `ARF_OFS_RESULT_HIGH) begin
                s_axi_rdata <= {24'h000000, shown_bytes[15:8]};
            end else if (s_axi_araddr == `ARF_OFS_STATUS) begin
                s_axi_rdata <= {30'h0, busy_r, done_flag_r};
            end else if (s_axi_araddr == `ARF_OFS_IRQ_CLEAR) begin
                s_axi_rdata <= 32'h00000000; // write-only
            end else if (s_axi_araddr == `ARF_OFS_IRQ_ENABLE) begin
                s_axi_rdata <= {31'h0, irq_enable_r};
            end else if (s_axi_araddr == `ARF_OFS_ACTIVE_SELECT) begin
                s_axi_rdata <= {24'h000000, active_reference, 1'b0, active_channel_gain};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `ARF_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // bind software; the protection bits carry no meaning here
    wire unused_ok;
    assign unused_ok = ^{s_axi_awprot, s_axi_arprot, w_strb_r[3:1], w_data_r[31:8]};

endmodule // arf_result_format

// File: verification/arf_result_format_properties.sv
// arf_result_format_properties.sv: port-level checks of the result-format block
// assumes: bound to arf_result_format, one aclk domain, aresetn active low
`timescale 1ns/1ps
module arf_checker (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire conv_start,
    input wire conv_finish,
    input wire conv_busy,
    input wire [1:0] active_reference,
    input wire ref_use_external_pin,
    input wire ref_use_analog_supply,
    input wire ref_use_internal,
    input wire [4:0] active_channel_gain,
    input wire active_differential,
    input wire [7:0] result_low_byte,
    input wire [7:0] result_high_byte
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_busy_on_start: assert property (conv_start && !conv_busy |=> conv_busy)
        else $error("busy missing after start");
    a_busy_on_finish: assert property (conv_finish && conv_busy |=> !conv_busy)
        else $error("busy stuck after finish");
    a_sel_frozen: assert property (conv_busy && !conv_finish |=>
        $stable(active_reference) && $stable(active_channel_gain))
        else $error("selection moved mid-conversion");
    a_result_held: assert property ((conv_busy && !conv_finish ##1 !$rose(s_axi_bvalid))
        |-> $stable(result_low_byte) && $stable(result_high_byte))
        else $error("result changed mid-conversion");
    a_ref_decode: assert property (ref_use_internal == (active_reference == 2'h3)
        && ref_use_analog_supply == (active_reference == 2'h1)
        && ref_use_external_pin == !active_reference[0])
        else $error("reference decode wrong");
    a_diff_decode: assert property (active_differential ==
        (active_channel_gain >= 5'h08 && active_channel_gain <= 5'h1D))
        else $error("differential decode wrong");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    // main scenarios reached
    cover property (conv_finish && conv_busy && active_differential);
    cover property ($rose(s_axi_bvalid) && conv_busy);
    cover property (conv_finish && conv_busy && ref_use_internal);
endmodule // arf_checker

bind arf_result_format arf_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .conv_start, .conv_finish, .conv_busy, .active_reference,
    .ref_use_external_pin, .ref_use_analog_supply, .ref_use_internal,
    .active_channel_gain, .active_differential, .result_low_byte, .result_high_byte);

// File: verification/tb_top.sv
// tb_top.sv: self-checking bench driving registers over axi4-lite and the converter pulses
// assumes: arf_result_format with its checker bound, 20 MHz aclk
`timescale 1ns/1ps
`include "arf_defs.vh"
module tb_top;
    logic aclk;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, conv_start = 0, conv_finish = 0;
    logic signed [11:0] conv_raw = 12'h000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_busy;
    wire ref_use_external_pin, ref_use_analog_supply, ref_use_internal, active_differential;
    wire irq;
    wire [1:0] s_axi_bresp, s_axi_rresp, active_reference;
    wire [31:0] s_axi_rdata;
    wire [4:0] active_channel_gain;
    wire [7:0] result_low_byte, result_high_byte;
    int failures = 0, n_tests = 0;
    logic [31:0] rd;
    int se_raw[5] = '{0, 1023, 1500, -5, 300};
    logic [9:0] se_exp[5] = '{10'h000, 10'h3FF, 10'h3FF, 10'h000, 10'h12C};
    int df_raw[5] = '{600, -600, -1, 511, -512};
    logic [9:0] df_exp[5] = '{10'h1FF, 10'h200, 10'h3FF, 10'h1FF, 10'h200};

    arf_result_format dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_finish, .conv_raw, .conv_busy,
        .active_reference, .ref_use_external_pin, .ref_use_analog_supply, .ref_use_internal,
        .active_channel_gain, .active_differential, .result_low_byte, .result_high_byte, .irq);

    // 50 ns clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // compare and count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
        @(posedge aclk);
    endtask

    // read one word
    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
        @(posedge aclk);
    endtask

    // converter pulses, result visible on return from cfin
    task automatic cstart();
        conv_start <= 1'b1;
        @(posedge aclk);
        conv_start <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic cfin(input int raw);
        conv_finish <= 1'b1;
        conv_raw <= raw[11:0];
        @(posedge aclk);
        conv_finish <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic doconv(input int raw);
        cstart();
        repeat (3) @(posedge aclk);
        cfin(raw);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        results();
    end

    // test sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(`ARF_OFS_INPUT_SELECT, rd, `ARF_RESP_OKAY);
        chk("sel reset", 16'h0000, rd[7:0]);
        chk("ext ref", 16'h0001, ref_use_external_pin);
        axw(`ARF_OFS_INPUT_SELECT, 8'hFF, `ARF_RESP_OKAY);
        axr(`ARF_OFS_INPUT_SELECT, rd, `ARF_RESP_OKAY);
        chk("sel rw", 16'h00FF, rd[7:0]);
        // no source sits on the external pin here, so every reference code may be tried
        for (int i = 0; i < 4; i++) begin
            axw(`ARF_OFS_INPUT_SELECT, {i[1:0], 6'h00}, `ARF_RESP_OKAY);
            chk("ref int", i == 3, ref_use_internal);
            chk("ref sup", i == 1, ref_use_analog_supply);
        end
        axr(8'h1C, rd, `ARF_RESP_SLVERR);
        axw(`ARF_OFS_RESULT_LOW, 8'h55, `ARF_RESP_SLVERR);
        // single-ended, right-justified, then flipped to left
        axw(`ARF_OFS_INPUT_SELECT, 8'h40, `ARF_RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            doconv(se_raw[i]);
            chk("se code", {6'h00, se_exp[i]}, {result_high_byte, result_low_byte});
        end
        axr(`ARF_OFS_STATUS, rd, `ARF_RESP_OKAY);
        chk("done", 16'h0001, rd[0]);
        axw(`ARF_OFS_INPUT_SELECT, 8'h60, `ARF_RESP_OKAY);
        chk("se left", {se_exp[4], 6'h00}, {result_high_byte, result_low_byte});
        // differential pair, internal reference, left then right
        axw(`ARF_OFS_INPUT_SELECT, 8'hED, `ARF_RESP_OKAY);
        doconv(-400);
        chk("diff left", 16'h9C00, {result_high_byte, result_low_byte});
        axr(`ARF_OFS_RESULT_HIGH, rd, `ARF_RESP_OKAY);
        chk("high byte rd", 16'h009C, rd[7:0]);
        axw(`ARF_OFS_INPUT_SELECT, 8'hCD, `ARF_RESP_OKAY);
        chk("diff right", 16'h0270, {result_high_byte, result_low_byte});
        axr(`ARF_OFS_RESULT_LOW, rd, `ARF_RESP_OKAY);
        chk("low byte rd", 16'h0070, rd[7:0]);
        for (int i = 0; i < 5; i++) begin
            doconv(df_raw[i]);
            chk("diff clamp", {6'h00, df_exp[i]}, {result_high_byte, result_low_byte});
            chk("sign", df_exp[i][9], result_high_byte[1]);
        end
        // selection written mid-conversion waits for the finish
        // while busy the bench moves converter pins only in cfin, which pulses conv_finish
        axw(`ARF_OFS_INPUT_SELECT, 8'h40, `ARF_RESP_OKAY);
        cstart();
        axw(`ARF_OFS_INPUT_SELECT, 8'hE9, `ARF_RESP_OKAY);
        chk("ref held", 16'h0001, active_reference);
        chk("chan held", 16'h0000, active_channel_gain);
        chk("busy pin", 16'h0001, conv_busy);
        axr(`ARF_OFS_STATUS, rd, `ARF_RESP_OKAY);
        chk("busy done", 16'h0003, rd[1:0]);
        axr(`ARF_OFS_ACTIVE_SELECT, rd, `ARF_RESP_OKAY);
        chk("sel held rd", 16'h0040, rd[7:0]);
        chk("live left", {df_exp[4], 6'h00}, {result_high_byte, result_low_byte});
        cfin(5);
        chk("ref applied", 16'h0003, active_reference);
        chk("chan applied", 16'h0009, active_channel_gain);
        chk("diff sel", 16'h0001, active_differential);
        chk("new result", 16'h0140, {result_high_byte, result_low_byte});
        // interrupt mask, enable and clear
        axw(`ARF_OFS_IRQ_ENABLE, 8'h00, `ARF_RESP_OKAY);
        chk("irq masked", 16'h0000, irq);
        axw(`ARF_OFS_IRQ_ENABLE, 8'h01, `ARF_RESP_OKAY);
        chk("irq on", 16'h0001, irq);
        axw(`ARF_OFS_IRQ_CLEAR, 8'h01, `ARF_RESP_OKAY);
        chk("irq clear", 16'h0000, irq);
        axr(`ARF_OFS_STATUS, rd, `ARF_RESP_OKAY);
        chk("done clear", 16'h0000, rd[0]);
        doconv(7);
        chk("irq again", 16'h0001, irq);
        results();
    end
endmodule // tb_top
